// >>> logic/codec_pkg.sv
package codec_pkg;
    // ---------------------------------------------
    // frame address and access classes
    // ---------------------------------------------
    localparam logic [15:0] REG_NUM_OFFSET = 16'h0001; // number = address + 1
    typedef enum logic [2:0] {
        ACC_READ = 3'h0,
        ACC_WRITE = 3'h1,
        ACC_READ_WRITE = 3'h2,
        ACC_COMMAND_READABLE = 3'h3,
        ACC_COMMAND_WRITABLE = 3'h4
    } access_class_t;

    // ---------------------------------------------
    // multi-word integers and float layout
    // ---------------------------------------------
    localparam logic [1:0] LAST_IDX_32 = 2'h1; // two words
    localparam logic [1:0] LAST_IDX_64 = 2'h3; // four words
    localparam int FLT_SIGN_POS = 31;
    localparam int FLT_EXP_LSB = 23;
    localparam int FLT_EXP_W = 8;
    localparam int FLT_MANT_W = 23;
    localparam logic [8:0] FLT_BIAS = 9'h07F;
    localparam logic [7:0] FLT_EXP_RSV = 8'hFF;

    // ---------------------------------------------
    // module date format: four words, first word on top
    // ---------------------------------------------
    localparam logic [1:0] DW_DAY_MONTH = 2'h0;
    localparam logic [1:0] DW_HOUR_YEAR = 2'h1;
    localparam logic [1:0] DW_SEC_MIN = 2'h2;
    localparam logic [1:0] DW_MSEC = 2'h3;
    localparam logic [7:0] DAY_MIN = 8'h01;
    localparam logic [7:0] DAY_MAX = 8'h1F;
    localparam logic [7:0] MONTH_MIN = 8'h01;
    localparam logic [7:0] MONTH_MAX = 8'h0C;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] MIN_SEC_MAX = 8'h3B;
    localparam logic [15:0] MSEC_MAX = 16'h03E7;
    localparam logic [7:0] YEAR_OLD_MIN = 8'h50;
    localparam logic [7:0] YEAR_OLD_MAX = 8'h63;
    localparam logic [7:0] YEAR_NEW_MIN = 8'h64;
    localparam logic [7:0] YEAR_NEW_MAX = 8'hC7;
    localparam logic [11:0] CAL_BASE_OLD = 12'h7BC; // 1980
    localparam logic [11:0] CAL_BASE_NEW = 12'h7D0; // 2000

    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000000; // one millisecond
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int SYNC_WINDOW_H = 2;
    localparam int SYNC_WINDOW_MS = SYNC_WINDOW_H * 3600 * 1000;

    // pick one 16-bit word of a four-word date
    function automatic logic [15:0] date_word(input logic [63:0] d, input logic [1:0] idx);
        date_word = d[6'(63 - 16 * int'(idx)) -: 16];
    endfunction
endpackage

// >>> logic/date_checker.sv
`timescale 1ns/10ps
// checks a module date and converts its year code
module date_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    date_if.judge dif
);
    import codec_pkg::*;

    // ---------------------------------------------
    // state
    // ---------------------------------------------
    typedef struct packed {
        logic done;
        logic ok;
        logic [11:0] cal_year;
    } chk_state_t;

    chk_state_t s; // registered state
    chk_state_t next_s; // next state
    logic [15:0] w_dm, w_hy, w_sm, w_ms; // the four words

    assign w_dm = date_word(dif.raw, DW_DAY_MONTH);
    assign w_hy = date_word(dif.raw, DW_HOUR_YEAR);
    assign w_sm = date_word(dif.raw, DW_SEC_MIN);
    assign w_ms = date_word(dif.raw, DW_MSEC);

    // range checks and year conversion
    always_comb begin
        next_s = s;
        next_s.done = dif.req;
        if (dif.req) begin
            next_s.ok = (w_dm[7:0] >= DAY_MIN) && (w_dm[7:0] <= DAY_MAX)
                && (w_dm[15:8] >= MONTH_MIN) && (w_dm[15:8] <= MONTH_MAX)
                && (w_hy[7:0] <= HOUR_MAX)
                && (w_hy[15:8] >= YEAR_OLD_MIN) && (w_hy[15:8] <= YEAR_NEW_MAX)
                && (w_sm[7:0] <= MIN_SEC_MAX) && (w_sm[15:8] <= MIN_SEC_MAX)
                && (w_ms <= MSEC_MAX);
            if (w_hy[15:8] <= YEAR_OLD_MAX) begin
                next_s.cal_year = CAL_BASE_OLD + {4'h0, w_hy[15:8] - YEAR_OLD_MIN};
            end else begin
                next_s.cal_year = CAL_BASE_NEW + {4'h0, w_hy[15:8] - YEAR_NEW_MIN};
            end
        end
    end

    // register the state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dif.done = s.done;
    assign dif.ok = s.ok;
    assign dif.cal_year = s.cal_year;
endmodule

// >>> logic/date_if.sv
`timescale 1ns/10ps
// carries one received date to the checker and its verdict back
interface date_if;
    logic req; // one-cycle request
    logic [63:0] raw; // four date words, first on top
    logic done; // verdict pulse
    logic ok; // all fields in range
    logic [11:0] cal_year; // calendar year
    modport judge (input req, input raw, output done, output ok, output cal_year);
    modport client (output req, output raw, input done, input ok, input cal_year);
endinterface

// >>> logic/register_value_codec.sv
`timescale 1ns/10ps
module register_value_codec #(
    parameter int TICK_CYC = codec_pkg::TICK_CYCLES,
    parameter int WINDOW_MS = codec_pkg::SYNC_WINDOW_MS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // access check
    input wire logic i_acc_valid,
    input wire logic [15:0] i_acc_addr,
    input wire codec_pkg::access_class_t i_acc_class,
    input wire logic i_acc_write,
    input wire logic i_acc_by_cmd,
    output logic o_acc_done,
    output logic [15:0] o_acc_reg_num,
    output logic o_acc_granted,
    // integer to words
    input wire logic i_pack_valid,
    input wire logic [63:0] i_pack_value,
    input wire logic i_pack_wide,
    output logic o_pack_ready,
    output logic o_tx_valid,
    output logic [15:0] o_tx_word,
    output logic o_tx_last,
    // words to integer and float
    input wire logic i_rx_valid,
    input wire logic i_rx_first,
    input wire logic [15:0] i_rx_word,
    input wire logic i_rx_wide,
    input wire logic i_rx_signed,
    output logic o_int_valid,
    output logic [63:0] o_int_value,
    output logic o_flt_sign,
    output logic [8:0] o_flt_exp,
    output logic [22:0] o_flt_mant,
    output logic o_flt_normal,
    // date and time from the master
    input wire logic i_sync_valid,
    input wire logic [63:0] i_sync_date,
    output logic o_bcast_valid,
    output logic [63:0] o_bcast_date,
    output logic [11:0] o_bcast_year,
    output logic o_date_error,
    output logic o_ext_synced
);
    import codec_pkg::*;

    // ---------------------------------------------
    // types and state
    // ---------------------------------------------
    // counter widths follow the parameters, so short test windows stay cheap
    localparam int TICK_W = $clog2(TICK_CYC + 1);
    localparam int MS_W = $clog2(WINDOW_MS + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    localparam logic [MS_W-1:0] WINDOW_LAST = MS_W'(WINDOW_MS);

    typedef enum logic [0:0] {
        PK_IDLE = 1'b0,
        PK_SEND = 1'b1
    } pack_state_t;

    typedef struct packed {
        pack_state_t pk_state;
        logic [63:0] pk_shift; // words still to send, next on top
        logic [1:0] pk_left; // words after the current one
        logic pack_ready;
        logic tx_valid;
        logic [15:0] tx_word;
        logic tx_last;
        logic [63:0] rx_acc; // gathered words, newest at bottom
        logic [1:0] rx_cnt; // index of last gathered word
        logic rx_wide;
        logic rx_signed;
        logic int_valid;
        logic [63:0] int_value;
        logic flt_sign;
        logic [8:0] flt_exp;
        logic [22:0] flt_mant;
        logic flt_normal;
        logic acc_done;
        logic [15:0] acc_reg_num;
        logic acc_granted;
        logic [63:0] pend_date; // date awaiting the verdict
        logic bc_valid;
        logic [63:0] bc_date;
        logic [11:0] bc_year;
        logic date_err;
        logic synced;
        logic [TICK_W-1:0] tick_cnt; // millisecond divider
        logic [MS_W-1:0] ms_cnt; // time since last sync
    } state_t;

    state_t s; // registered state
    state_t next_s; // next state
    date_if dif (); // link to the date checker

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    // is this access legal for its class and path
    function automatic logic access_allowed(input access_class_t cls, input logic wr, input logic by_cmd);
        logic ok;
        ok = 1'b0;
        if (by_cmd) begin
            ok = wr ? (cls == ACC_COMMAND_WRITABLE) : (cls == ACC_COMMAND_READABLE);
        end else begin
            ok = wr ? (cls == ACC_WRITE || cls == ACC_READ_WRITE) : (cls == ACC_READ || cls == ACC_READ_WRITE);
        end
        return ok;
    endfunction

    // index of the last word of an integer
    function automatic logic [1:0] last_idx(input logic wide);
        return wide ? LAST_IDX_64 : LAST_IDX_32;
    endfunction

    // ---------------------------------------------
    // date checker
    // ---------------------------------------------
    // the checker answers one cycle later; the date waits in pend_date
    // so that the broadcast carries exactly the words that were judged
    assign dif.req = i_sync_valid;
    assign dif.raw = i_sync_date;

    date_checker u_check (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .dif (dif.judge)
    );

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb begin
        next_s = s;
        next_s.tx_valid = 1'b0;
        next_s.tx_last = 1'b0;
        next_s.int_valid = 1'b0;
        next_s.acc_done = 1'b0;
        next_s.bc_valid = 1'b0;
        next_s.date_err = 1'b0;

        // class check is pure decode; its answer is registered like every output
        // access decode, one cycle after the request
        if (i_acc_valid) begin
            next_s.acc_done = 1'b1;
            next_s.acc_reg_num = i_acc_addr + REG_NUM_OFFSET;
            next_s.acc_granted = access_allowed(i_acc_class, i_acc_write, i_acc_by_cmd);
        end

        // the shift register holds the top word at bit 63, so a 32-bit
        // value is moved up before its two words go out
        // serialiser: one word per cycle, no stall
        unique case (s.pk_state)
            PK_IDLE: begin
                next_s.pack_ready = 1'b1;
                // taken only while ready shows; the cycle after reset is refused
                if (i_pack_valid && s.pack_ready) begin
                    next_s.pk_shift = i_pack_wide ? i_pack_value : {i_pack_value[31:0], 32'h0};
                    next_s.pk_left = last_idx(i_pack_wide);
                    next_s.pk_state = PK_SEND;
                    next_s.pack_ready = 1'b0;
                end
            end
            PK_SEND: begin
                next_s.tx_valid = 1'b1;
                next_s.tx_word = s.pk_shift[63:48];
                next_s.pk_shift = {s.pk_shift[47:0], 16'h0};
                if (s.pk_left == 2'h0) begin
                    // last word: ready again next cycle
                    next_s.tx_last = 1'b1;
                    next_s.pk_state = PK_IDLE;
                    next_s.pack_ready = 1'b1;
                end else begin
                    next_s.pk_left = s.pk_left - 2'h1;
                end
            end
        endcase

        // limitation: words beyond the count keep shifting; the master must
        // flag the first word of every value to realign the gatherer
        // gatherer: words arrive most significant first
        if (i_rx_valid) begin
            if (i_rx_first) begin
                // a first word restarts any partial value
                next_s.rx_acc = {48'h0, i_rx_word};
                next_s.rx_cnt = 2'h0;
                next_s.rx_wide = i_rx_wide;
                next_s.rx_signed = i_rx_signed;
            end else begin
                next_s.rx_acc = {s.rx_acc[47:0], i_rx_word};
                next_s.rx_cnt = s.rx_cnt + 2'h1;
                if (next_s.rx_cnt == last_idx(s.rx_wide)) begin
                    next_s.int_valid = 1'b1;
                    if (s.rx_wide) begin
                        next_s.int_value = next_s.rx_acc;
                    end else if (s.rx_signed) begin
                        next_s.int_value = {{32{next_s.rx_acc[31]}}, next_s.rx_acc[31:0]};
                    end else begin
                        next_s.int_value = {32'h0, next_s.rx_acc[31:0]};
                    end
                    next_s.flt_sign = next_s.rx_acc[FLT_SIGN_POS];
                    next_s.flt_mant = next_s.rx_acc[FLT_EXP_LSB-1:0];
                    next_s.flt_exp = {1'b0, next_s.rx_acc[FLT_EXP_LSB +: FLT_EXP_W]} - FLT_BIAS;
                    next_s.flt_normal = (next_s.rx_acc[FLT_EXP_LSB +: FLT_EXP_W] != 8'h00)
                        && (next_s.rx_acc[FLT_EXP_LSB +: FLT_EXP_W] != FLT_EXP_RSV);
                end
            end
        end

        // hold the date while the checker looks at it
        if (i_sync_valid) begin
            next_s.pend_date = i_sync_date;
        end

        // millisecond tick from the divider
        if (s.tick_cnt == TICK_LAST) begin
            next_s.tick_cnt = '0;
            if (s.synced) begin
                next_s.ms_cnt = s.ms_cnt + MS_W'(1);
            end
        end else begin
            next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
        end

        // the divider restarts with each good date, so sync lasts the whole
        // window plus one cycle and never drops a fraction of a tick early
        // expire after the window
        if (s.synced && s.ms_cnt >= WINDOW_LAST) begin
            next_s.synced = 1'b0;
        end

        // verdict on a received date
        if (dif.done) begin
            if (dif.ok) begin
                next_s.bc_valid = 1'b1;
                next_s.bc_date = s.pend_date;
                next_s.bc_year = dif.cal_year;
                next_s.synced = 1'b1;
                next_s.ms_cnt = '0;
                // restart the divider too, so the window is whole milliseconds
                next_s.tick_cnt = '0;
            end else begin
                next_s.date_err = 1'b1;
            end
        end
    end

    // ---------------------------------------------
    // state register
    // ---------------------------------------------
    // one synchronous reset clears all; ready comes up one cycle later
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------
    // outputs, all straight from the state register
    // ---------------------------------------------
    // nothing is decoded on the way out, so the far side sees clean levels
    assign o_acc_done = s.acc_done;
    assign o_acc_reg_num = s.acc_reg_num;
    assign o_acc_granted = s.acc_granted;
    assign o_pack_ready = s.pack_ready;
    assign o_tx_valid = s.tx_valid;
    assign o_tx_word = s.tx_word;
    assign o_tx_last = s.tx_last;
    assign o_int_valid = s.int_valid;
    assign o_int_value = s.int_value;
    assign o_flt_sign = s.flt_sign;
    assign o_flt_exp = s.flt_exp;
    assign o_flt_mant = s.flt_mant;
    assign o_flt_normal = s.flt_normal;
    assign o_bcast_valid = s.bc_valid;
    assign o_bcast_date = s.bc_date;
    assign o_bcast_year = s.bc_year;
    assign o_date_error = s.date_err;
    assign o_ext_synced = s.synced;
endmodule

// >>> test/master_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// master handing received register words in
// ---------------------------------------------
module master_model (
    input wire logic i_clk,
    output logic o_valid,
    output logic o_first,
    output logic [15:0] o_word,
    output logic o_wide,
    output logic o_signed
);
    initial begin
        o_valid = 1'b0;
        o_first = 1'b0;
        o_word = 16'h0000;
        o_wide = 1'b0;
        o_signed = 1'b0;
    end
    task automatic send(input logic [63:0] v, input logic w, input logic s, input int gap);
        int n;
        n = w ? 4 : 2;
        for (int k = n - 1; k >= 0; k--) begin
            // a slow master leaves gaps where the line keeps changing
            if (k != n - 1) repeat (gap) begin
                @(negedge i_clk);
                o_valid = 1'b0;
                o_word = ~o_word;
            end
            @(negedge i_clk);
            o_valid = 1'b1;
            o_first = k == n - 1;
            o_word = v[16 * k +: 16];
            o_wide = w;
            o_signed = s;
        end
        @(negedge i_clk);
        o_valid = 1'b0;
        o_word = ~o_word;
    endtask
endmodule

// >>> test/register_value_codec_asserts.sv
`timescale 1ns/10ps
// ---------------------------------------------
// port timing checker of the codec
// ---------------------------------------------
module register_value_codec_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_acc_valid,
    input wire logic [15:0] i_acc_addr,
    input wire codec_pkg::access_class_t i_acc_class,
    input wire logic i_acc_write,
    input wire logic i_acc_by_cmd,
    input wire logic o_acc_done,
    input wire logic [15:0] o_acc_reg_num,
    input wire logic o_acc_granted,
    input wire logic i_pack_valid,
    input wire logic [63:0] i_pack_value,
    input wire logic i_pack_wide,
    input wire logic o_pack_ready,
    input wire logic o_tx_valid,
    input wire logic [15:0] o_tx_word,
    input wire logic o_tx_last,
    input wire logic i_sync_valid,
    input wire logic [63:0] i_sync_date,
    input wire logic o_bcast_valid,
    input wire logic [63:0] o_bcast_date,
    input wire logic [11:0] o_bcast_year,
    input wire logic o_date_error,
    input wire logic o_ext_synced
);
    import codec_pkg::*;
    logic want; // grant that the class and direction deserve
    logic [63:0] pv; // value of the accepted pack request
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // direct functions reach plain classes, the command path the command classes
    assign want = i_acc_by_cmd ? (i_acc_class == (i_acc_write ? ACC_COMMAND_WRITABLE : ACC_COMMAND_READABLE))
        : (i_acc_class == ACC_READ_WRITE || i_acc_class == (i_acc_write ? ACC_WRITE : ACC_READ));
    // capture only when taken, so a refused pulse cannot disturb it
    always_ff @(posedge i_clk) begin
        if (i_pack_valid && o_pack_ready) begin
            pv <= i_pack_value;
        end
    end
    chk_acc_number: assert property (
        i_acc_valid |=> o_acc_done && o_acc_reg_num == $past(i_acc_addr) + 16'h0001)
        else $error("register number not address plus one");
    chk_acc_grant: assert property (
        i_acc_valid |=> o_acc_granted == $past(want)) else $error("access grant wrong for class");
    chk_pack_narrow: assert property (
        i_pack_valid && o_pack_ready && !i_pack_wide |-> ##2 o_tx_valid && !o_tx_last && o_tx_word == pv[31:16]
        ##1 o_tx_valid && o_tx_last && o_tx_word == pv[15:0]) else $error("two-word order wrong");
    chk_pack_wide: assert property (
        i_pack_valid && o_pack_ready && i_pack_wide |-> ##2 o_tx_word == pv[63:48] ##1 o_tx_word == pv[47:32]
        ##1 o_tx_word == pv[31:16] ##1 o_tx_last && o_tx_word == pv[15:0]) else $error("four-word order wrong");
    chk_tx_burst: assert property (
        o_tx_valid && !o_tx_last |=> o_tx_valid) else $error("word burst broken");
    chk_date_verdict: assert property (
        i_sync_valid |-> ##2 (o_bcast_valid ^ o_date_error) && (!o_bcast_valid || o_bcast_date == $past(i_sync_date, 2)))
        else $error("date neither forwarded nor rejected");
    chk_year_map: assert property (
        o_bcast_valid |-> o_bcast_year == 12'(o_bcast_date[47:40]) + 12'h76C) else $error("calendar year wrong");
    chk_sync_hold: assert property (
        o_bcast_valid |=> o_ext_synced [*8]) else $error("sync not held after good date");
    chk_bad_nosync: assert property (
        o_date_error && !o_ext_synced |=> !o_ext_synced) else $error("rejected date set sync");
endmodule
bind register_value_codec register_value_codec_asserts i_register_value_codec_asserts (.*);

// >>> test/register_value_codec_bench.sv
`timescale 1ns/10ps
// ---------------------------------------------
// self-checking bench of the codec
// ---------------------------------------------
module register_value_codec_bench;
    import codec_pkg::*;
    localparam int TK = 4; // ms tick, shortened
    localparam int WM = 5; // sync window in ticks, shortened
    logic i_clk = 1'b0, i_rst = 1'b1;
    logic i_acc_valid = 1'b0, i_acc_write = 1'b0, i_acc_by_cmd = 1'b0;
    logic i_pack_valid = 1'b0, i_pack_wide = 1'b0, i_sync_valid = 1'b0;
    logic [15:0] i_acc_addr = 16'h0000;
    access_class_t i_acc_class = ACC_READ;
    logic [63:0] i_pack_value = '0, i_sync_date = '0;
    logic i_rx_valid, i_rx_first, i_rx_wide, i_rx_signed;
    logic [15:0] i_rx_word, o_acc_reg_num, o_tx_word;
    logic o_acc_done, o_acc_granted, o_pack_ready, o_tx_valid, o_tx_last, o_int_valid;
    logic o_flt_sign, o_flt_normal, o_bcast_valid, o_date_error, o_ext_synced;
    logic [63:0] o_int_value, o_bcast_date;
    logic [8:0] o_flt_exp;
    logic [22:0] o_flt_mant;
    logic [11:0] o_bcast_year;
    int n_fail = 0, check_count = 0, cyc = 0, t0;
    logic [31:0] seed = 32'h0000003F; // xorshift state
    logic [15:0] tx_q[$], exp_q[$]; // words seen and words due
    // boundary dates: five good, then one bad field each
    logic [63:0] dt [15] = '{64'h0C1F_C717_3B3B_03E7, 64'h0101_5000_0000_0000, 64'h0C01_7000_0000_0000,
        64'h0101_6300_0000_0000, 64'h0101_6400_0000_0000, 64'h0C00_C717_3B3B_03E7, 64'h0C20_C717_3B3B_03E7,
        64'h001F_C717_3B3B_03E7, 64'h0D1F_C717_3B3B_03E7, 64'h0C1F_C718_3B3B_03E7, 64'h0C1F_4F17_3B3B_03E7,
        64'h0C1F_C817_3B3B_03E7, 64'h0C1F_C717_3B3C_03E7, 64'h0C1F_C717_3C3B_03E7, 64'h0C1F_C717_3B3B_03E8};

    register_value_codec #(.TICK_CYC(TK), .WINDOW_MS(WM)) i_register_value_codec (.*);
    master_model i_master_model (.i_clk(i_clk), .o_valid(i_rx_valid), .o_first(i_rx_first), .o_word(i_rx_word),
        .o_wide(i_rx_wide), .o_signed(i_rx_signed));

    always #5 i_clk = ~i_clk;
    // cycle count and word monitor
    always @(posedge i_clk) begin
        cyc++;
        if (o_tx_valid === 1'b1) begin
            tx_q.push_back(o_tx_word);
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic grant(input int cl, input logic w, input logic c);
        if (c) begin
            return w ? cl == 4 : cl == 3;
        end
        return cl == 2 || cl == (w ? 1 : 0);
    endfunction
    function automatic logic date_ok(input logic [63:0] d);
        return d[55:48] inside {[8'h01:8'h1F]} && d[63:56] inside {[8'h01:8'h0C]} && d[39:32] <= 8'h17
            && d[47:40] inside {[8'h50:8'hC7]} && d[31:24] <= 8'h3B && d[23:16] <= 8'h3B && d[15:0] <= 16'h03E7;
    endfunction
    function automatic logic [11:0] year_of(input logic [7:0] y);
        return y <= 8'h63 ? 12'h7BC + 12'(y - 8'h50) : 12'h7D0 + 12'(y - 8'h64);
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic acc(input int cl, input logic w, input logic c, input logic [15:0] a);
        @(negedge i_clk);
        i_acc_valid = 1'b1;
        i_acc_class = access_class_t'(cl);
        i_acc_write = w;
        i_acc_by_cmd = c;
        i_acc_addr = a;
        @(negedge i_clk);
        i_acc_valid = 1'b0;
        chk("acc_done", 1, o_acc_done);
        chk("reg_num", 16'(a + 16'h0001), o_acc_reg_num);
        chk("granted", grant(cl, w, c), o_acc_granted);
    endtask
    // request, then a refused pulse with another value while busy
    task automatic pack(input logic [63:0] v, input logic w);
        for (int t = 0; t < 10 && o_pack_ready !== 1'b1; t++) @(negedge i_clk);
        i_pack_valid = 1'b1;
        i_pack_value = v;
        i_pack_wide = w;
        for (int j = w ? 3 : 1; j >= 0; j--) exp_q.push_back(v[16 * j +: 16]);
        @(negedge i_clk);
        i_pack_value = ~v;
        @(negedge i_clk);
        i_pack_valid = 1'b0;
    endtask
    task automatic date(input logic [63:0] d);
        @(negedge i_clk);
        i_sync_valid = 1'b1;
        i_sync_date = d;
        @(negedge i_clk);
        i_sync_valid = 1'b0;
        @(negedge i_clk);
        chk("bcast", date_ok(d), o_bcast_valid);
        chk("error", !date_ok(d), o_date_error);
        if (date_ok(d)) begin
            chk("date", d, o_bcast_date);
            chk("year", year_of(d[47:40]), o_bcast_year);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        end_sim();
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        logic [63:0] v;
        logic [63:0] e;
        logic w;
        logic s;
        int k;
        repeat (8) @(negedge i_clk);
        chk("reset", 0, {o_pack_ready, o_acc_done, o_tx_valid, o_bcast_valid, o_ext_synced});
        i_rst = 1'b0;
        @(negedge i_clk);
        for (k = 0; k < 20; k++) begin
            acc(k % 5, k[0], k >= 10, k == 19 ? 16'hFFFF : 16'(xs()));
        end
        for (k = 0; k < 10; k++) begin
            pack({xs(), xs()}, k[0]);
        end
        repeat (8) @(negedge i_clk);
        chk("tx_count", exp_q.size(), tx_q.size());
        foreach (exp_q[j]) chk("tx_word", exp_q[j], tx_q[j]);
        // two worked values, minus one and a half, then random ones
        for (k = 0; k < 14; k++) begin
            v = k == 0 ? 64'h0000_0000_FFF2_A96E : k == 1 ? 64'h0000_0000_0017_9692 : {xs(), xs()};
            v = k == 2 ? 64'h0000_0000_BFC0_0000 : v;
            w = k == 1 || (k > 2 && k[1]);
            s = k < 3 || k[2];
            i_master_model.send(v, w, s, k % 3);
            e = w ? v : s ? {{32{v[31]}}, v[31:0]} : {32'h0000_0000, v[31:0]};
            chk("int_valid", 1, o_int_valid);
            chk("int_value", e, o_int_value);
            chk("flt_sign", v[31], o_flt_sign);
            chk("flt_exp", 9'(9'(v[30:23]) - 9'h07F), o_flt_exp);
            chk("flt_mant", v[22:0], o_flt_mant);
            chk("flt_normal", v[30:23] != 8'h00 && v[30:23] != 8'hFF, o_flt_normal);
        end
        foreach (dt[j]) date(dt[j]);
        for (k = 0; k < 8; k++) begin
            date({xs(), xs()} & 64'h0F1F_FF1F_3F3F_03FF);
        end
        date(dt[0]);
        t0 = cyc;
        date(dt[5]);
        chk("synced", 1, o_ext_synced);
        for (k = 0; k < 60 && o_ext_synced === 1'b1; k++) @(negedge i_clk);
        chk("window", 1, cyc - t0 >= WM * TK && cyc - t0 <= (WM + 2) * TK + 4);
        date(dt[6]);
        chk("unsynced", 0, o_ext_synced);
        end_sim();
    end
endmodule
